// >>> chg_host_model.sv
// host-side bus master model: drives the link clock and pulls the data wire.
// assumes the bench resolves sda with a pull-up and feeds it back on sda_i.
`timescale 1ns/1ns
`default_nettype none
module chg_host_model import chg_pkg::*; (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_pull_o
);
  // released lines idle high; scl stands still between frames
  initial begin
    scl_o = 1'h1;
    sda_pull_o = 1'h0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // a quarter of the 160 ns link period, launched just after an edge
  task automatic quarter();
    repeat (5) @(posedge clk_i);
    #1;
  endtask
  task automatic start();
    sda_pull_o = 1'h0;
    quarter();
    scl_o = 1'h1;
    quarter();
    sda_pull_o = 1'h1;  // data falls while clock high
    quarter();
    scl_o = 1'h0;
    quarter();
  endtask
  task automatic stop();
    sda_pull_o = 1'h1;
    quarter();
    scl_o = 1'h1;
    quarter();
    sda_pull_o = 1'h0;  // data rises while clock high
    quarter();
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_pull_o = ~b;  // changed only while clock low
    quarter();
    scl_o = 1'h1;
    quarter();
    r = sda_i;  // sampled inside the high pulse
    quarter();
    scl_o = 1'h0;
    quarter();
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);  // msb first
    bit_io(1'h1, r);  // ninth pulse answered by the target
    ack = ~r;
  endtask
  task automatic recv(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'h1, r);
      d[i] = r;
    end
    bit_io(last, r);  // ack low byte, nack high byte
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // only word transfers are ever issued
  task automatic write_word(input logic [6:0] a, input logic [7:0] c,
                            input logic [15:0] d, output logic [3:0] acks);
    start();
    send({a, 1'h0}, acks[3]);
    send(c, acks[2]);
    send(d[7:0], acks[1]);  // low byte first
    send(d[15:8], acks[0]);
    stop();
  endtask
  task automatic read_word(input logic [7:0] c, output logic [15:0] d,
                           output logic [2:0] acks);
    start();
    send({TARGET_ADDR, 1'h0}, acks[2]);
    send(c, acks[1]);
    start();  // repeated start
    send({TARGET_ADDR, 1'h1}, acks[0]);
    recv(1'h0, d[7:0]);
    recv(1'h1, d[15:8]);
    stop();
  endtask
endmodule
`default_nettype wire

// >>> chg_pkg.sv
// package for the charger two-wire target: command codes, field layout,
// reset values and the carrier types shared by the design.
// assumes a single clock domain; the target synchronises its own pins.
package chg_pkg;

  localparam logic [6:0] TARGET_ADDR = 7'h09;

  localparam logic [7:0] CMD_CFG_A     = 8'h12;
  localparam logic [7:0] CMD_CHG_CUR   = 8'h14;
  localparam logic [7:0] CMD_CHG_VOLT  = 8'h15;
  localparam logic [7:0] CMD_STATE     = 8'h20;
  localparam logic [7:0] CMD_THROTTLE  = 8'h21;
  localparam logic [7:0] CMD_IIN_LIMIT = 8'h22;
  localparam logic [7:0] CMD_ADC_VP    = 8'h23;
  localparam logic [7:0] CMD_ADC_IBAT  = 8'h24;
  localparam logic [7:0] CMD_CFG_B     = 8'h30;
  localparam logic [7:0] CMD_CFG_C     = 8'h31;
  localparam logic [7:0] CMD_CFG_D     = 8'h32;
  localparam logic [7:0] CMD_THR_A     = 8'h33;
  localparam logic [7:0] CMD_THR_B     = 8'h34;
  localparam logic [7:0] CMD_SAMPLING  = 8'h35;
  localparam logic [7:0] CMD_MAKER_ID  = 8'hFE;
  localparam logic [7:0] CMD_PART_ID   = 8'hFF;

  // field positions inside the 16-bit words
  localparam int CUR_LSB  = 6;
  localparam int VOLT_LSB = 4;
  localparam int IIN_LSB  = 8;
  localparam int OVP_BIT  = 4;

  localparam logic [15:0] CFG_A_RST = 16'hE20E;
  localparam logic [15:0] CFG_B_RST = 16'h0000;
  localparam logic [15:0] CFG_C_RST = 16'h0000;
  localparam logic [15:0] CFG_D_RST = 16'h0000;
  localparam logic [15:0] THR_A_RST = 16'h0000;
  localparam logic [15:0] THR_B_RST = 16'h0000;
  localparam logic [15:0] SAMP_RST  = 16'h0000;
  localparam logic [6:0]  CUR_RST   = 7'h00;

  // charge voltage defaults per cell count, in 16 mV steps
  localparam logic [10:0] VOLT_1CELL = 11'h106;
  localparam logic [10:0] VOLT_2CELL = 11'h20D;
  localparam logic [10:0] VOLT_3CELL = 11'h313;
  localparam logic [10:0] VOLT_4CELL = 11'h41A;

  localparam int THR_W  = 7;
  localparam int SYNC_W = 13;
  // link clock and data idle high, so no false edge follows reset
  localparam logic [SYNC_W-1:0] SYNC_RST = 13'h1800;

  typedef struct packed {
    logic [15:0] cfg_a;
    logic [15:0] cfg_b;
    logic [15:0] cfg_c;
    logic [15:0] cfg_d;
    logic [15:0] thr_a;
    logic [15:0] thr_b;
    logic [15:0] sampling;
    logic [6:0]  charge_current_setpoint;
    logic [10:0] charge_voltage_limit;
  } chg_cfg_t;

  typedef struct packed {
    logic [7:0] system_power_result;
    logic [7:0] input_voltage_result;
    logic [7:0] charge_current_result;
    logic [7:0] discharge_current_result;
    logic [6:0] active_input_current_limit;
  } chg_meas_t;

  typedef enum {ST_IDLE, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK, ST_IGNORE} chg_st_t;

endpackage

// >>> chg_smbus_target.sv
// two-wire word-read/word-write target with the charger command registers.
// assumes scl/sda and status pins are asynchronous; measurements come from
// logic on ref_clk_i. sda is open drain: testbench resolves the wire.
`timescale 1ns/1ns
`default_nettype none
module chg_smbus_target
  import chg_pkg::*;
#(
  parameter logic [15:0] MAKER_ID = 16'h5A5A,  // arbitrary value
  parameter logic [15:0] PART_ID  = 16'h0A0A   // arbitrary value
) (
  input  wire logic              ref_clk_i,
  input  wire logic              rst_i,
  input  wire logic              scl_i,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe_o,
  input  wire logic              supply_ok_i,
  input  wire logic [1:0]        cell_count_i,
  input  wire logic [THR_W-1:0]  throttle_event_i,
  input  wire logic              sys_ovp_event_i,
  input  wire chg_meas_t         meas_i,
  output chg_cfg_t               cfg_o,
  output logic                   ovp_latched_o
);

  ////////////////////////////////////////////////////////////////////////
  // synchronisers: first stage read only by the second

  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic              scl_p_q;
  logic              sda_p_q;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_q <= SYNC_RST;
      sync2_q <= SYNC_RST;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      sync1_q <= {scl_i, sda_i, supply_ok_i, cell_count_i, throttle_event_i, sys_ovp_event_i};
      sync2_q <= sync1_q;
      scl_p_q <= sync2_q[12];
      sda_p_q <= sync2_q[11];
    end
  end

  logic             scl_s;
  logic             sda_s;
  logic             supply_s;
  logic [1:0]       cell_s;
  logic [THR_W-1:0] thr_act_s;
  logic             ovp_s;
  assign {scl_s, sda_s, supply_s, cell_s, thr_act_s, ovp_s} = sync2_q;

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_rise  = scl_s & ~scl_p_q;
  assign scl_fall  = ~scl_s & scl_p_q;
  assign start_det = scl_s & scl_p_q & ~sda_s & sda_p_q;
  assign stop_det  = scl_s & scl_p_q & sda_s & ~sda_p_q;

  function automatic logic [10:0] volt_default(input logic [1:0] cells);
    case (cells)
      2'h0:    volt_default = VOLT_1CELL;
      2'h1:    volt_default = VOLT_2CELL;
      2'h2:    volt_default = VOLT_3CELL;
      default: volt_default = VOLT_4CELL;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // bus engine

  chg_st_t     state_q;
  logic [3:0]  bit_cnt_q;
  logic [7:0]  shift_q;
  logic [1:0]  byte_idx_q;
  logic [7:0]  cmd_q;
  logic [7:0]  wr_lo_q;
  logic [15:0] rd_word_q;
  logic        rd_mode_q;
  logic        ack_drv_q;
  logic        sda_oe_q;
  logic        wr_commit;
  logic [15:0] rd_mux;

  // byte complete on the eighth rising edge
  assign wr_commit = (state_q == ST_RX) && scl_rise && (bit_cnt_q == 4'h7) && supply_s
                     && (byte_idx_q == 2'h3);

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q    <= ST_IDLE;
      bit_cnt_q  <= 4'h0;
      shift_q    <= 8'h00;
      byte_idx_q <= 2'h0;
      cmd_q      <= 8'h00;
      wr_lo_q    <= 8'h00;
      rd_word_q  <= 16'h0000;
      rd_mode_q  <= 1'b0;
      ack_drv_q  <= 1'b0;
      sda_oe_q   <= 1'b0;
    end else if (!supply_s) begin
      state_q  <= ST_IDLE;
      sda_oe_q <= 1'b0;
    end else if (start_det) begin
      // repeated start keeps the command code for the read phase
      state_q    <= ST_RX;
      bit_cnt_q  <= 4'h0;
      byte_idx_q <= 2'h0;
      sda_oe_q   <= 1'b0;
    end else if (stop_det) begin
      state_q  <= ST_IDLE;
      sda_oe_q <= 1'b0;
    end else begin
      case (state_q)
        ST_RX: begin
          if (scl_rise) begin
            shift_q   <= {shift_q[6:0], sda_s};
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (bit_cnt_q == 4'h7) begin
              bit_cnt_q <= 4'h0;
              ack_drv_q <= 1'b0;
              state_q   <= ST_RX_ACK;
              if (byte_idx_q == 2'h0) begin
                rd_mode_q <= sda_s;
                if (shift_q[6:0] != TARGET_ADDR) begin
                  state_q <= ST_IGNORE;
                end else if (sda_s) begin
                  rd_word_q <= rd_mux;
                end
              end else if (byte_idx_q == 2'h1) begin
                cmd_q <= {shift_q[6:0], sda_s};
              end else if (byte_idx_q == 2'h2) begin
                wr_lo_q <= {shift_q[6:0], sda_s};
              end
            end
          end
        end
        ST_RX_ACK: begin
          // pull low across the ninth pulse, release on the fall after it
          if (scl_fall && !ack_drv_q) begin
            sda_oe_q  <= 1'b1;
            ack_drv_q <= 1'b1;
          end else if (scl_fall) begin
            byte_idx_q <= byte_idx_q + 2'h1;
            if (rd_mode_q && byte_idx_q == 2'h0) begin
              shift_q  <= rd_word_q[7:0];  // low byte first
              sda_oe_q <= ~rd_word_q[7];
              state_q  <= ST_TX;
            end else if (byte_idx_q == 2'h3) begin
              sda_oe_q <= 1'b0;  // only stop or start may follow
              state_q  <= ST_IGNORE;
            end else begin
              sda_oe_q <= 1'b0;
              state_q  <= ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
            shift_q   <= {shift_q[6:0], 1'b0};
            if (bit_cnt_q == 4'h7) begin
              bit_cnt_q <= 4'h0;
              state_q   <= ST_TX_ACK;
            end
          end else if (scl_fall) begin
            sda_oe_q <= ~shift_q[7];
          end
        end
        ST_TX_ACK: begin
          if (scl_fall) begin
            sda_oe_q <= 1'b0;  // master owns the ninth bit
          end else if (scl_rise) begin
            if (!sda_s && byte_idx_q == 2'h1) begin
              byte_idx_q <= 2'h2;
              shift_q    <= rd_word_q[15:8];
              state_q    <= ST_TX;
            end else begin
              state_q <= ST_IGNORE;
            end
          end
        end
        ST_IGNORE: sda_oe_q <= 1'b0;
        default: begin
          state_q  <= ST_IDLE;
          sda_oe_q <= 1'b0;
        end
      endcase
    end
  end

  // first bit of the high byte goes out on the fall that ends the ack pulse
  assign sda_oe_o = sda_oe_q;

  ////////////////////////////////////////////////////////////////////////
  // command registers

  chg_cfg_t         cfg_q;
  logic             volt_written_q;
  logic             ovp_q;
  logic [THR_W-1:0] thr_q;
  logic [THR_W-1:0] thr_mark_q;
  logic             sda_zero_q;
  logic [15:0]      wr_word;
  logic             rd_load;

  assign wr_word = {shift_q[6:0], sda_s, wr_lo_q};
  assign rd_load = (state_q == ST_RX) && scl_rise && (bit_cnt_q == 4'h7)
                   && (byte_idx_q == 2'h0) && sda_s && (shift_q[6:0] == TARGET_ADDR);

  always_comb begin
    case (cmd_q)
      CMD_CFG_A:     rd_mux = cfg_q.cfg_a;
      CMD_CHG_CUR:   rd_mux = 16'(cfg_q.charge_current_setpoint) << CUR_LSB;
      CMD_CHG_VOLT:  rd_mux = 16'(cfg_q.charge_voltage_limit) << VOLT_LSB;
      CMD_STATE:     rd_mux = 16'(ovp_q) << OVP_BIT;
      CMD_THROTTLE:  rd_mux = 16'(thr_q);
      CMD_IIN_LIMIT: rd_mux = 16'(meas_i.active_input_current_limit) << IIN_LSB;
      CMD_ADC_VP:    rd_mux = {meas_i.system_power_result,
                               meas_i.input_voltage_result};
      CMD_ADC_IBAT:  rd_mux = {meas_i.charge_current_result,
                               meas_i.discharge_current_result};
      CMD_CFG_B:     rd_mux = cfg_q.cfg_b;
      CMD_CFG_C:     rd_mux = cfg_q.cfg_c;
      CMD_CFG_D:     rd_mux = cfg_q.cfg_d;
      CMD_THR_A:     rd_mux = cfg_q.thr_a;
      CMD_THR_B:     rd_mux = cfg_q.thr_b;
      CMD_SAMPLING:  rd_mux = cfg_q.sampling;
      CMD_MAKER_ID:  rd_mux = MAKER_ID;
      CMD_PART_ID:   rd_mux = PART_ID;
      default:       rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_q.cfg_a                   <= CFG_A_RST;
      cfg_q.cfg_b                   <= CFG_B_RST;
      cfg_q.cfg_c                   <= CFG_C_RST;
      cfg_q.cfg_d                   <= CFG_D_RST;
      cfg_q.thr_a                   <= THR_A_RST;
      cfg_q.thr_b                   <= THR_B_RST;
      cfg_q.sampling                <= SAMP_RST;
      cfg_q.charge_current_setpoint <= CUR_RST;
      cfg_q.charge_voltage_limit    <= VOLT_1CELL;
      volt_written_q                <= 1'b0;
    end else begin
      // voltage limit follows the cell strap until the host writes it
      if (!volt_written_q) begin
        cfg_q.charge_voltage_limit <= volt_default(cell_s);
      end
      if (wr_commit) begin
        case (cmd_q)
          CMD_CFG_A:    cfg_q.cfg_a <= wr_word;
          CMD_CFG_B:    cfg_q.cfg_b <= wr_word;
          CMD_CFG_C:    cfg_q.cfg_c <= wr_word;
          CMD_CFG_D:    cfg_q.cfg_d <= wr_word;
          CMD_THR_A:    cfg_q.thr_a <= wr_word;
          CMD_THR_B:    cfg_q.thr_b <= wr_word;
          CMD_SAMPLING: cfg_q.sampling <= wr_word;
          CMD_CHG_CUR:  cfg_q.charge_current_setpoint <= wr_word[CUR_LSB +: 7];
          CMD_CHG_VOLT: begin
            cfg_q.charge_voltage_limit <= wr_word[VOLT_LSB +: 11];
            volt_written_q             <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end

  // event set wins over host clear in both status groups
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ovp_q <= 1'b0;
    end else if (ovp_s) begin
      ovp_q <= 1'b1;
    end else if (wr_commit && cmd_q == CMD_STATE && !wr_word[OVP_BIT]) begin
      ovp_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      thr_q      <= '0;
      thr_mark_q <= '0;
    end else begin
      thr_q <= thr_act_s | (thr_q & ~(thr_mark_q & ~thr_act_s));
      if (rd_load && cmd_q == CMD_THROTTLE) begin
        thr_mark_q <= thr_q;
      end else begin
        thr_mark_q <= thr_mark_q & thr_q & thr_act_s;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sda_zero_q    <= 1'b0;
      ovp_latched_o <= 1'b0;
    end else begin
      sda_zero_q    <= 1'b0;  // open drain never drives high
      ovp_latched_o <= ovp_q;
    end
  end

  assign sda_o = sda_zero_q;
  assign cfg_o = cfg_q;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  a_lockout_release: assert property (!supply_s |=> !sda_oe_q)
    else $error("sda driven while supply locked out");
  a_idle_quiet: assert property (state_q == ST_IDLE |-> !sda_oe_q)
    else $error("sda driven while idle");
  a_open_drain: assert property (sda_o == 1'b0)
    else $error("sda driven high");
  a_change_scl_low: assert property (
      $changed(sda_oe_q) && $past(supply_s) && !$past(start_det) && !$past(stop_det)
      |-> !$past(scl_s))
    else $error("sda changed while scl high");
  a_addr_match: assert property (
      $rose(state_q == ST_RX_ACK) && byte_idx_q == 2'h0 |-> shift_q[7:1] == TARGET_ADDR)
    else $error("acknowledged wrong address");
  a_byte_length: assert property (
      state_q == ST_RX && scl_rise && bit_cnt_q == 4'h7 && supply_s && !start_det
      && !stop_det |=> state_q inside {ST_RX_ACK, ST_IGNORE})
    else $error("byte not closed after eight bits");
  a_ack_low: assert property (
      state_q == ST_RX_ACK && scl_fall && !ack_drv_q && supply_s && !start_det
      && !stop_det |=> sda_oe_q ##1 sda_oe_q)
    else $error("acknowledge not driven low");
  a_msb_first: assert property (
      state_q == ST_TX && scl_fall && supply_s && !start_det && !stop_det
      |=> sda_oe_q == ~shift_q[7])
    else $error("transmit bit order wrong");
  a_maker_const: assert property (
      state_q == ST_TX && cmd_q == CMD_MAKER_ID |-> rd_word_q == MAKER_ID)
    else $error("maker identifier changed");
  a_ovp_set_wins: assert property (ovp_s |=> ovp_q)
    else $error("overvoltage latch lost");
  a_throttle_hold: assert property (
      ((~thr_q & $past(thr_q) & ~($past(thr_mark_q) & ~$past(thr_act_s))) == '0))
    else $error("throttle flag cleared early");
  a_ro_untouched: assert property (
      wr_commit && cmd_q == CMD_IIN_LIMIT |=> $stable(cfg_q))
    else $error("read-only write changed state");

  c_word_write: cover property (wr_commit);
  c_word_read: cover property (state_q == ST_TX_ACK && byte_idx_q == 2'h2 && scl_rise);
  c_addr_nack: cover property ($rose(state_q == ST_IGNORE) && byte_idx_q == 2'h0);

endmodule
`default_nettype wire

// >>> chg_smbus_target_test.sv
// self-checking bench for the charger two-wire target.
// assumes chg_host_model as bus master and a pull-up on the data wire.
`timescale 1ns/1ns
`default_nettype none
module chg_smbus_target_test import chg_pkg::*;;
  localparam logic [15:0] MAKER = 16'hC3A5;  // arbitrary value
  localparam logic [15:0] PART  = 16'h3C5A;  // arbitrary value
  localparam logic [7:0] RW_CMDS [7] = '{CMD_CFG_A, CMD_CFG_B, CMD_CFG_C,
    CMD_CFG_D, CMD_THR_A, CMD_THR_B, CMD_SAMPLING};
  logic             clk = 1'h0;
  logic             rst = 1'h1;
  logic             supply_ok = 1'h1;
  logic             ovp_ev = 1'h0;
  logic [1:0]       cells = 2'h0;
  logic [THR_W-1:0] thr_ev = '0;
  chg_meas_t        meas = '0;
  chg_cfg_t         cfg;
  chg_cfg_t         keep;
  logic             scl, sda, sda_o, dut_oe, host_pull, ovp_q;
  logic [3:0]       a;
  int               errors = 0;
  int               n_compared = 0;
  always #4 clk = ~clk;
  // open-drain wire with pull-up
  assign sda = (dut_oe ? sda_o : 1'h1) & ~host_pull;
  chg_smbus_target #(.MAKER_ID(MAKER), .PART_ID(PART)) dut (
    .ref_clk_i(clk), .rst_i(rst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_o(dut_oe), .supply_ok_i(supply_ok), .cell_count_i(cells),
    .throttle_event_i(thr_ev), .sys_ovp_event_i(ovp_ev), .meas_i(meas),
    .cfg_o(cfg), .ovp_latched_o(ovp_q));
  chg_host_model host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_pull_o(host_pull));
  ////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    logic [3:0] k;
    host.write_word(TARGET_ADDR, c, d, k);
    chk({12'h000, k}, 16'h000F);
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] exp,
                    input logic [15:0] m = 16'hFFFF);
    logic [15:0] d;
    logic [2:0]  k;
    host.read_word(c, d, k);
    chk({13'h0000, k}, 16'h0007);
    chk(d & m, exp);
  endtask
  task automatic wrap_up();
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // generous bound: the whole sequence needs well under half of this
  initial begin
    #600000;
    errors++;
    $display("ERROR %0t: watchdog expired", $time);
    wrap_up();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(8);
    rst = 1'h0;
    tick(10);
    chk({5'h00, cfg.charge_voltage_limit}, 16'(4192 / 16));
    cells = 2'h3;
    tick(6);
    chk({5'h00, cfg.charge_voltage_limit}, 16'(16800 / 16));
    cells = 2'h1;
    tick(6);
    chk({5'h00, cfg.charge_voltage_limit}, 16'(8400 / 16));
    cells = 2'h2;
    tick(6);
    chk({5'h00, cfg.charge_voltage_limit}, 16'(12592 / 16));
    rd(CMD_CFG_A, CFG_A_RST);
    supply_ok = 1'h0;
    tick(5);
    host.write_word(TARGET_ADDR, CMD_CHG_CUR, 16'h1FC0, a);
    chk({12'h000, a}, 16'h0000);
    supply_ok = 1'h1;
    tick(5);
    host.write_word(7'h0A, CMD_CHG_CUR, 16'h1FC0, a);
    chk({12'h000, a}, 16'h0000);
    chk({9'h000, cfg.charge_current_setpoint}, 16'h0000);
    wr(CMD_CHG_CUR, 16'h1FC0);
    chk({9'h000, cfg.charge_current_setpoint}, 16'(8128 / 64));
    rd(CMD_CHG_CUR, 16'h1FC0);
    wr(CMD_CHG_VOLT, 16'h20D0);
    cells = 2'h0;
    tick(6);
    chk({5'h00, cfg.charge_voltage_limit}, 16'(8400 / 16));
    rd(CMD_CHG_VOLT, 16'h20D0);
    for (int i = 0; i < 7; i++) begin
      wr(RW_CMDS[i], 16'hA500 | 16'(i));
      rd(RW_CMDS[i], 16'hA500 | 16'(i));
    end
    rd(CMD_MAKER_ID, MAKER);
    wr(CMD_MAKER_ID, 16'h0000);
    rd(CMD_MAKER_ID, MAKER);
    rd(CMD_PART_ID, PART);
    keep = cfg;
    wr(8'h40, 16'hFFFF);
    chk({15'h0000, cfg === keep}, 16'h0001);
    meas = '{8'hA5, 8'h3C, 8'h81, 8'h7E, 7'h55};
    rd(CMD_ADC_VP, 16'hA53C);
    rd(CMD_ADC_IBAT, 16'h817E);
    wr(CMD_IIN_LIMIT, 16'h0000);
    rd(CMD_IIN_LIMIT, 16'h5500);
    ovp_ev = 1'h1;
    tick(5);
    ovp_ev = 1'h0;
    tick(5);
    chk({15'h0000, ovp_q}, 16'h0001);
    rd(CMD_STATE, 16'h0010, 16'h0010);
    wr(CMD_STATE, 16'h0000);
    tick(2);
    chk({15'h0000, ovp_q}, 16'h0000);
    thr_ev = 7'h05;
    tick(5);
    thr_ev = 7'h00;
    tick(5);
    rd(CMD_THROTTLE, 16'h0005, 16'h007F);
    rd(CMD_THROTTLE, 16'h0000, 16'h007F);
    thr_ev = 7'h02;
    tick(5);
    rd(CMD_THROTTLE, 16'h0002, 16'h007F);
    rd(CMD_THROTTLE, 16'h0002, 16'h007F);
    thr_ev = 7'h00;
    tick(5);
    rd(CMD_THROTTLE, 16'h0000, 16'h007F);
    chk({14'h0000, dut_oe, ~sda}, 16'h0000);
    wrap_up();
  end
endmodule
`default_nettype wire
